// ==== hdl/tcr_timer_regs.sv ====
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Function
// - force strobes act only in non-pwm modes
// - force applies match to wave output
// - force sets no flag, clears no counter
// - force bits are pulses, read zero
// - control b bits 5:4 read zero
// - clock select stops, passes or divides
// - counter register read and write access
// - counter write blocks next tick match
// - compare registers matched against counter continuously
// - channel b irq needs mask, global, flag
// - channel a irq needs mask, global, flag
// - overflow irq needs mask, global, flag
// - match b sets flag bit 2
// - match a sets flag bit 1
// - vector acknowledge clears its flag
// - write one clears flag, zero keeps
// - overflow flag at max or phase correct bottom
// - three mode bits pick counting behaviour
// ------------------------------
// timer register block, apb slave
// ------------------------------
module tcr_timer_regs (
    // clock and reset
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // timer source tick and global enable
    input  wire logic        TIMER_SRC_CLK,
    input  wire logic        GLOBAL_IRQ_EN,
    // interrupt requests and acknowledges
    output logic             IRQ_MATCH_A,
    output logic             IRQ_MATCH_B,
    output logic             IRQ_OVERFLOW,
    input  wire logic        ACK_MATCH_A,
    input  wire logic        ACK_MATCH_B,
    input  wire logic        ACK_OVERFLOW,
    // waveform outputs
    output logic             WAVE_OUT_A,
    output logic             WAVE_OUT_B
);

    // ------------------------------
    // state
    // ------------------------------
    typedef struct packed {
        logic [7:0] control_a;     // mode a, mode b, lower wave bits
        logic       wave_upper;    // upper waveform mode bit
        logic [2:0] clk_sel;       // clock select
        logic [7:0] timer_count;   // counter
        logic [7:0] compare_a;     // compare value a
        logic [7:0] compare_b;     // compare value b
        logic [2:0] irq_mask;      // mask bits 2:0
        logic [2:0] irq_flags;     // flag bits 2:0
        logic       down;          // phase correct direction
        logic       block_match;   // counter written, block next tick
        logic [31:0] rdata;        // read data register
    } tcr_regs_t;

    tcr_regs_t st;       // registered state
    tcr_regs_t next_st;  // next state

    logic       tick;        // selected timer tick
    logic       wr;          // apb write access
    logic       rd;          // apb read access
    logic       hit;         // mapped address
    logic [2:0] wmode;       // full waveform mode
    logic       is_pwm;      // pwm modes
    logic       is_fast;     // fast pwm modes
    logic       is_pc;       // phase correct modes
    logic [7:0] top;         // current top value
    logic       at_top;      // counter at top
    logic       match_a;     // channel a match
    logic       match_b;     // channel b match
    logic       force_a;     // force strobe a pulse
    logic       force_b;     // force strobe b pulse
    logic       ovf;         // overflow event
    logic [7:0] wdat;        // write byte

    // ------------------------------
    // decode
    // ------------------------------
    assign wr      = PSEL && PENABLE && PWRITE;
    assign rd      = PSEL && !PENABLE && !PWRITE;
    assign wdat    = PWDATA[7:0];
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign PRDATA  = st.rdata;

    // address hit check
    always_comb begin
        unique case (PADDR)
            tcr_pkg::OFF_CONTROL_A, tcr_pkg::OFF_CONTROL_B, tcr_pkg::OFF_COUNT,
            tcr_pkg::OFF_CMP_A, tcr_pkg::OFF_CMP_B, tcr_pkg::OFF_MASK,
            tcr_pkg::OFF_FLAGS: hit = 1'b1;
            default:            hit = 1'b0;
        endcase
    end

    // mode decode
    assign wmode   = {st.wave_upper, st.control_a[tcr_pkg::CA_WAVE_LSB +: 2]};
    assign is_pwm  = wmode[0];
    assign is_fast = is_pwm && wmode[1];
    assign is_pc   = is_pwm && !wmode[1];
    assign top     = wmode[2] ? st.compare_a : tcr_pkg::CNT_MAX;
    assign at_top  = (st.timer_count == top);

    // force strobes, pulses for one cycle of a write
    assign force_a = wr && (PADDR == tcr_pkg::OFF_CONTROL_B) && wdat[tcr_pkg::CB_FORCE_A];
    assign force_b = wr && (PADDR == tcr_pkg::OFF_CONTROL_B) && wdat[tcr_pkg::CB_FORCE_B];

    // overflow: max in normal/ctc/fast, bottom reversal in phase correct
    assign ovf = tick && (is_pc ? (st.down && st.timer_count == 8'h01)
                                : (st.timer_count == tcr_pkg::CNT_MAX));

    // ------------------------------
    // submodules
    // ------------------------------
    tcr_prescaler u_psc (
        .CORE_CLK (CORE_CLK),
        .RST      (RST),
        .src_tick (TIMER_SRC_CLK),
        .clk_sel  (st.clk_sel),
        .tick     (tick)
    );

    tcr_wave_chan u_cha (
        .CORE_CLK    (CORE_CLK),
        .RST         (RST),
        .tick        (tick),
        .count       (st.timer_count),
        .cmp         (st.compare_a),
        .block_match (st.block_match),
        .is_pwm      (is_pwm),
        .is_fast     (is_fast),
        .at_top      (at_top),
        .down        (st.down),
        .out_mode    (st.control_a[tcr_pkg::CA_MODE_A_LSB +: 2]),
        .force_match (force_a),
        .match       (match_a),
        .wave        (WAVE_OUT_A)
    );

    tcr_wave_chan u_chb (
        .CORE_CLK    (CORE_CLK),
        .RST         (RST),
        .tick        (tick),
        .count       (st.timer_count),
        .cmp         (st.compare_b),
        .block_match (st.block_match),
        .is_pwm      (is_pwm),
        .is_fast     (is_fast),
        .at_top      (at_top),
        .down        (st.down),
        .out_mode    (st.control_a[tcr_pkg::CA_MODE_B_LSB +: 2]),
        .force_match (force_b),
        .match       (match_b),
        .wave        (WAVE_OUT_B)
    );

    // ------------------------------
    // next state
    // ------------------------------
    always_comb begin
        next_st = st;
        // block flag lasts until the next tick
        if (tick) begin
            next_st.block_match = 1'b0;
        end
        // counting
        if (tick) begin
            if (is_pc) begin
                if (!st.down && at_top) begin
                    next_st.down        = 1'b1;
                    next_st.timer_count = st.timer_count - 8'h01;
                end else if (st.down && st.timer_count == 8'h01) begin
                    next_st.down        = 1'b0;
                    next_st.timer_count = tcr_pkg::CNT_BOTTOM;
                end else if (st.down) begin
                    next_st.timer_count = st.timer_count - 8'h01;
                end else begin
                    next_st.timer_count = st.timer_count + 8'h01;
                end
            end else if ((wmode == tcr_pkg::WM_CTC && match_a) || at_top) begin
                // clear on match in ctc only on a real match, never forced
                next_st.timer_count = tcr_pkg::CNT_BOTTOM;
            end else begin
                next_st.timer_count = st.timer_count + 8'h01;
            end
        end
        // register writes
        if (wr) begin
            unique case (PADDR)
                tcr_pkg::OFF_CONTROL_A: begin
                    next_st.control_a = wdat & 8'hF3;
                end
                tcr_pkg::OFF_CONTROL_B: begin
                    next_st.wave_upper = wdat[tcr_pkg::CB_WAVE_UP];
                    next_st.clk_sel    = wdat[tcr_pkg::CB_CS_LSB +: 3];
                end
                tcr_pkg::OFF_COUNT: begin
                    next_st.timer_count = wdat;
                    next_st.block_match = 1'b1;
                    next_st.down        = 1'b0;
                end
                tcr_pkg::OFF_CMP_A: begin
                    next_st.compare_a = wdat;
                end
                tcr_pkg::OFF_CMP_B: begin
                    next_st.compare_b = wdat;
                end
                tcr_pkg::OFF_MASK: begin
                    next_st.irq_mask = wdat[2:0];
                end
                tcr_pkg::OFF_FLAGS: begin
                    next_st.irq_flags = st.irq_flags & ~wdat[2:0];
                end
                default: begin
                end
            endcase
        end
        // vector acknowledges clear flags
        if (ACK_MATCH_B) begin
            next_st.irq_flags[tcr_pkg::BIT_MATCH_B] = 1'b0;
        end
        if (ACK_MATCH_A) begin
            next_st.irq_flags[tcr_pkg::BIT_MATCH_A] = 1'b0;
        end
        if (ACK_OVERFLOW) begin
            next_st.irq_flags[tcr_pkg::BIT_OVF] = 1'b0;
        end
        // hardware set wins over any clear; forced matches never reach here
        if (match_b) begin
            next_st.irq_flags[tcr_pkg::BIT_MATCH_B] = 1'b1;
        end
        if (match_a) begin
            next_st.irq_flags[tcr_pkg::BIT_MATCH_A] = 1'b1;
        end
        if (ovf) begin
            next_st.irq_flags[tcr_pkg::BIT_OVF] = 1'b1;
        end
        // read data captured in setup phase
        if (rd) begin
            unique case (PADDR)
                tcr_pkg::OFF_CONTROL_A: next_st.rdata = {24'h0, st.control_a};
                // strobes and bits 5:4 read zero
                tcr_pkg::OFF_CONTROL_B: next_st.rdata = {24'h0, 4'h0,
                                                         st.wave_upper, st.clk_sel};
                tcr_pkg::OFF_COUNT:     next_st.rdata = {24'h0, st.timer_count};
                tcr_pkg::OFF_CMP_A:     next_st.rdata = {24'h0, st.compare_a};
                tcr_pkg::OFF_CMP_B:     next_st.rdata = {24'h0, st.compare_b};
                tcr_pkg::OFF_MASK:      next_st.rdata = {29'h0, st.irq_mask};
                tcr_pkg::OFF_FLAGS:     next_st.rdata = {29'h0, st.irq_flags};
                default:                next_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------
    // interrupt requests, mask and global enable and flag
    // ------------------------------
    assign IRQ_MATCH_B  = GLOBAL_IRQ_EN && st.irq_mask[tcr_pkg::BIT_MATCH_B]
                          && st.irq_flags[tcr_pkg::BIT_MATCH_B];
    assign IRQ_MATCH_A  = GLOBAL_IRQ_EN && st.irq_mask[tcr_pkg::BIT_MATCH_A]
                          && st.irq_flags[tcr_pkg::BIT_MATCH_A];
    assign IRQ_OVERFLOW = GLOBAL_IRQ_EN && st.irq_mask[tcr_pkg::BIT_OVF]
                          && st.irq_flags[tcr_pkg::BIT_OVF];

    // ------------------------------
    // state register
    // ------------------------------
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : tcr_timer_regs
`default_nettype wire

// ==== inc/tcr_pkg.sv ====
// ----------------------------------------------------------------------------
// timer register block constants
// ----------------------------------------------------------------------------
package tcr_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] OFF_CONTROL_A = 8'h00;  // lower mode bits, output modes
    localparam logic [7:0] OFF_CONTROL_B = 8'h04;  // strobes, upper mode, clock select
    localparam logic [7:0] OFF_COUNT     = 8'h08;  // counter value
    localparam logic [7:0] OFF_CMP_A     = 8'h0C;  // compare value a
    localparam logic [7:0] OFF_CMP_B     = 8'h10;  // compare value b
    localparam logic [7:0] OFF_MASK      = 8'h14;  // interrupt mask
    localparam logic [7:0] OFF_FLAGS     = 8'h18;  // interrupt flags, write one to clear

    // control register b field positions
    localparam int CB_FORCE_A = 7;  // force match a strobe
    localparam int CB_FORCE_B = 6;  // force match b strobe
    localparam int CB_WAVE_UP = 3;  // upper waveform mode bit
    localparam int CB_CS_LSB  = 0;  // clock select low bit

    // control register a field positions
    localparam int CA_MODE_A_LSB = 6;  // output mode a
    localparam int CA_MODE_B_LSB = 4;  // output mode b
    localparam int CA_WAVE_LSB   = 0;  // lower waveform mode bits

    // mask and flag bit positions
    localparam int BIT_MATCH_B = 2;  // channel b compare
    localparam int BIT_MATCH_A = 1;  // channel a compare
    localparam int BIT_OVF     = 0;  // overflow

    // reset values
    localparam logic [7:0] RST_REG = 8'h00;  // all registers reset to zero

    // counter limits
    localparam logic [7:0] CNT_MAX    = 8'hFF;  // max value
    localparam logic [7:0] CNT_BOTTOM = 8'h00;  // bottom value

    // prescaler taps, divide ratio minus one
    localparam logic [9:0] DIV_8    = 10'h007;
    localparam logic [9:0] DIV_32   = 10'h01F;
    localparam logic [9:0] DIV_64   = 10'h03F;
    localparam logic [9:0] DIV_128  = 10'h07F;
    localparam logic [9:0] DIV_256  = 10'h0FF;
    localparam logic [9:0] DIV_1024 = 10'h3FF;

    // waveform modes, upper bit then lower two
    localparam logic [2:0] WM_NORMAL  = 3'h0;
    localparam logic [2:0] WM_PC_FF   = 3'h1;
    localparam logic [2:0] WM_CTC     = 3'h2;
    localparam logic [2:0] WM_FAST_FF = 3'h3;
    localparam logic [2:0] WM_PC_OCA  = 3'h5;
    localparam logic [2:0] WM_FAST_OC = 3'h7;

endpackage : tcr_pkg

// ==== hdl/tcr_prescaler.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// prescaler: one-cycle tick enable from the source clock enable
// ----------------------------------------------------------------------------
module tcr_prescaler (
    // clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    // source tick and selection
    input  wire logic       src_tick,
    input  wire logic [2:0] clk_sel,
    // selected tick
    output logic            tick
);

    // state of the prescaler
    typedef struct packed {
        logic [9:0] div;  // free running divider
    } tcr_psc_t;

    tcr_psc_t st;       // registered state
    tcr_psc_t next_st;  // next state
    logic [9:0] mask;   // tap mask for selection

    // divider advances on every source tick
    always_comb begin
        next_st = st;
        if (src_tick) begin
            next_st.div = st.div + 10'h001;
        end
    end

    // select tap mask and produce the tick
    always_comb begin
        unique case (clk_sel)
            3'h2:    mask = tcr_pkg::DIV_8;
            3'h3:    mask = tcr_pkg::DIV_32;
            3'h4:    mask = tcr_pkg::DIV_64;
            3'h5:    mask = tcr_pkg::DIV_128;
            3'h6:    mask = tcr_pkg::DIV_256;
            3'h7:    mask = tcr_pkg::DIV_1024;
            default: mask = 10'h000;
        endcase
        // stopped at zero, undivided at one, divided otherwise
        if (clk_sel == 3'h0) begin
            tick = 1'b0;
        end else begin
            tick = src_tick && ((st.div & mask) == mask);
        end
    end

    // state register
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : tcr_prescaler
`default_nettype wire

// ==== hdl/tcr_wave_chan.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------------
// one compare channel: match detect and waveform output
// ----------------------------------------------------------------------------
module tcr_wave_chan (
    // clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    // counter view
    input  wire logic       tick,
    input  wire logic [7:0] count,
    input  wire logic [7:0] cmp,
    input  wire logic       block_match,
    input  wire logic       is_pwm,
    input  wire logic       is_fast,
    input  wire logic       at_top,
    input  wire logic       down,
    // output mode and force strobe
    input  wire logic [1:0] out_mode,
    input  wire logic       force_match,
    // results
    output logic            match,
    output logic            wave
);

    // channel state
    typedef struct packed {
        logic wave;  // waveform output
    } tcr_wch_t;

    tcr_wch_t st;       // registered state
    tcr_wch_t next_st;  // next state

    // compare always, block on the tick after a counter write
    assign match = tick && !block_match && (count == cmp);

    // waveform update on real or forced match outside pwm, on real match or fast pwm top in pwm
    always_comb begin
        next_st = st;
        if (!is_pwm) begin
            // force applies like a match but touches nothing else
            if (match || force_match) begin
                unique case (out_mode)
                    2'h1:    next_st.wave = !st.wave;
                    2'h2:    next_st.wave = 1'b0;
                    2'h3:    next_st.wave = 1'b1;
                    default: next_st.wave = st.wave;
                endcase
            end
        end else if (out_mode[1]) begin
            // pwm: clear/set on match, reversed at fast pwm top or down count
            if (match) begin
                next_st.wave = out_mode[0] ^ down;
            end else if (is_fast && tick && at_top) begin
                next_st.wave = !out_mode[0];
            end
        end
    end

    assign wave = st.wave;

    // state register
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : tcr_wave_chan
`default_nettype wire

// ==== test/tcr_timer_regs_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// port checker for the timer register block
// ------------------------------
module tcr_timer_regs_checker (
    // clock and reset
    input wire logic        CORE_CLK,
    input wire logic        RST,
    // apb slave
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PSLVERR,
    // timer, interrupts, waveform
    input wire logic        TIMER_SRC_CLK,
    input wire logic        GLOBAL_IRQ_EN,
    input wire logic        IRQ_MATCH_A,
    input wire logic        IRQ_MATCH_B,
    input wire logic        IRQ_OVERFLOW,
    input wire logic        ACK_MATCH_A,
    input wire logic        WAVE_OUT_A
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    wire acc = PSEL && PENABLE;  // access phase
    wire wr  = acc && PWRITE;    // write taking effect
    // write access, then the setup of a read of the same place
    sequence s_wr(a);
        wr && PADDR == a;
    endsequence
    sequence s_rd_setup(a);
        PSEL && !PENABLE && !PWRITE && PADDR == a;
    endsequence
    chk_ctrl_b_zero: assert property (
        acc && !PWRITE && PADDR == tcr_pkg::OFF_CONTROL_B |-> PRDATA[7:4] == 4'h0)
        else $error("control b strobe or reserved bits read nonzero");
    chk_upper_zero: assert property (acc && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("read data above bit 7 nonzero");
    chk_hole_refused: assert property (
        acc && PADDR > tcr_pkg::OFF_FLAGS |-> PSLVERR && (PWRITE || PRDATA == 32'h0))
        else $error("unmapped access not refused");
    chk_irq_gate: assert property (
        IRQ_MATCH_A || IRQ_MATCH_B || IRQ_OVERFLOW |-> GLOBAL_IRQ_EN)
        else $error("request without global enable");
    chk_cmp_echo: assert property (
        s_wr(tcr_pkg::OFF_CMP_A) ##1 s_rd_setup(tcr_pkg::OFF_CMP_A)
        |=> PRDATA[7:0] == $past(PWDATA[7:0], 2))
        else $error("compare a reads back wrong");
    chk_wave_hold: assert property (
        (!TIMER_SRC_CLK && !wr)[*2] |=> $stable(WAVE_OUT_A))
        else $error("waveform a moved without tick or write");
    chk_ack_clear: assert property (
        ACK_MATCH_A && !TIMER_SRC_CLK && !$past(TIMER_SRC_CLK) |=> !IRQ_MATCH_A)
        else $error("acknowledge left request a up");
    chk_w1c_a: assert property (
        wr && PADDR == tcr_pkg::OFF_FLAGS && PWDATA[tcr_pkg::BIT_MATCH_A]
        && !TIMER_SRC_CLK && !$past(TIMER_SRC_CLK) |=> !IRQ_MATCH_A)
        else $error("write one left flag a set");
    chk_w0_keep: assert property (
        wr && PADDR == tcr_pkg::OFF_FLAGS && !PWDATA[tcr_pkg::BIT_MATCH_A]
        && IRQ_MATCH_A && !ACK_MATCH_A |=> IRQ_MATCH_A || !GLOBAL_IRQ_EN)
        else $error("write zero cleared flag a");
endmodule : tcr_timer_regs_checker
bind tcr_timer_regs tcr_timer_regs_checker i_chk (
    .CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PSLVERR,
    .TIMER_SRC_CLK, .GLOBAL_IRQ_EN, .IRQ_MATCH_A, .IRQ_MATCH_B, .IRQ_OVERFLOW,
    .ACK_MATCH_A, .WAVE_OUT_A
);
`default_nettype wire

// ==== test/tcr_irq_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// interrupt controller model: runs the vector of each pending request
// ------------------------------
module tcr_irq_ctrl_model (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // service enable and answer latency in cycles
    input wire logic       ack_en,
    input wire logic [7:0] lat,
    // requests and vector acknowledges, {overflow, b, a}
    input wire logic [2:0] irq,
    output logic     [2:0] ack
);
    logic [7:0] wait_cnt [3];  // cycles each request has waited
    // one acknowledge pulse per pending request once the latency ran out
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack <= 3'h0;
            wait_cnt <= '{default: 8'h00};
        end else begin
            for (int i = 0; i < 3; i++) begin
                ack[i] <= 1'b0;
                if (!ack_en || irq[i] !== 1'b1 || ack[i]) begin
                    wait_cnt[i] <= 8'h00;  // idle, or vector just taken
                end else if (wait_cnt[i] == lat) begin
                    ack[i] <= 1'b1;  // vector executed
                    wait_cnt[i] <= 8'h00;
                end else begin
                    wait_cnt[i] <= wait_cnt[i] + 8'h01;
                end
            end
        end
    end
endmodule : tcr_irq_ctrl_model
`default_nettype wire

// ==== test/tcr_timer_regs_test.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// self-checking bench for the timer register block
// ------------------------------
module tcr_timer_regs_test;
    logic        clk = 1'b0, rst = 1'b1, gie = 1'b1, src = 1'b0;  // clock, reset, enables
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;      // apb request
    logic [7:0]  paddr = 8'h00;                                   // apb address
    logic [31:0] pwdata = 32'h0, prdata, rd;                      // apb data, last read
    logic        pready, pslverr, err, wave_a, wave_b, ack_en = 1'b0;
    logic [2:0]  irq, ack;                                        // {overflow, b, a}
    int          n_mismatch = 0, checks = 0;
    int          div [8] = '{4, 1, 8, 32, 64, 128, 256, 1024};  // source steps per count
    always #2.5 clk = ~clk;
    tcr_timer_regs i_dut (
        .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TIMER_SRC_CLK(src), .GLOBAL_IRQ_EN(gie),
        .IRQ_MATCH_A(irq[0]), .IRQ_MATCH_B(irq[1]), .IRQ_OVERFLOW(irq[2]),
        .ACK_MATCH_A(ack[0]), .ACK_MATCH_B(ack[1]), .ACK_OVERFLOW(ack[2]),
        .WAVE_OUT_A(wave_a), .WAVE_OUT_B(wave_b));
    tcr_irq_ctrl_model i_ctrl (.clk(clk), .rst(rst), .ack_en(ack_en), .lat(8'h03),
        .irq(irq), .ack(ack));
    // compare one result and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; the bus is released by the next call or by cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask : apb
    // read one register and compare it
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    // release the bus, hold the source tick for n cycles, then settle
    task automatic cyc(input logic s, input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        src <= s;
        repeat (n) @(posedge clk);
        src <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : cyc
    // verdict and end of run
    task automatic tally_and_finish;
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) rchk(8'(4 * i), 32'h0);
        rchk(8'h1C, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, tcr_pkg::OFF_CONTROL_B, 32'hF8);
        rchk(tcr_pkg::OFF_CONTROL_B, 32'h08);
        // compare values; a counter write masks the very next match
        apb(1'b1, tcr_pkg::OFF_CMP_A, 32'h12);
        rchk(tcr_pkg::OFF_CMP_A, 32'h12);
        apb(1'b1, tcr_pkg::OFF_CMP_B, 32'h12);
        apb(1'b1, tcr_pkg::OFF_MASK, 32'hFF);
        rchk(tcr_pkg::OFF_MASK, 32'h07);
        apb(1'b1, tcr_pkg::OFF_CONTROL_B, 32'h01);
        apb(1'b1, tcr_pkg::OFF_COUNT, 32'h12);
        cyc(1'b1, 1);
        rchk(tcr_pkg::OFF_FLAGS, 32'h0);
        rchk(tcr_pkg::OFF_COUNT, 32'h13);
        apb(1'b1, tcr_pkg::OFF_COUNT, 32'h11);
        cyc(1'b1, 2);
        rchk(tcr_pkg::OFF_FLAGS, 32'h06);
        chk(irq, 3'b011);
        gie <= 1'b0;
        cyc(1'b0, 1);
        chk(irq, 3'b000);
        gie <= 1'b1;
        apb(1'b1, tcr_pkg::OFF_FLAGS, 32'h04);
        rchk(tcr_pkg::OFF_FLAGS, 32'h02);
        // the controller runs the vector of request a
        ack_en <= 1'b1;
        cyc(1'b0, 8);
        ack_en <= 1'b0;
        rchk(tcr_pkg::OFF_FLAGS, 32'h0);
        // overflow at max, masked and then unmasked
        apb(1'b1, tcr_pkg::OFF_MASK, 32'h06);
        apb(1'b1, tcr_pkg::OFF_COUNT, 32'hFF);
        cyc(1'b1, 1);
        rchk(tcr_pkg::OFF_FLAGS, 32'h01);
        chk(irq, 3'b000);
        apb(1'b1, tcr_pkg::OFF_MASK, 32'h07);
        rchk(tcr_pkg::OFF_MASK, 32'h07);
        chk(irq, 3'b100);
        apb(1'b1, tcr_pkg::OFF_FLAGS, 32'h07);
        rchk(tcr_pkg::OFF_FLAGS, 32'h0);
        // every clock select code over two periods of its divider
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, tcr_pkg::OFF_CONTROL_B, 32'(s));
            apb(1'b1, tcr_pkg::OFF_COUNT, 32'h0);
            cyc(1'b1, 2 * div[s]);
            rchk(tcr_pkg::OFF_COUNT, (s == 0) ? 32'h0 : 32'h2);
        end
        // forced matches in clear-on-match mode, then ignored in pwm
        apb(1'b1, tcr_pkg::OFF_CONTROL_A, 32'h72);
        apb(1'b1, tcr_pkg::OFF_COUNT, 32'h12);
        apb(1'b1, tcr_pkg::OFF_CONTROL_B, 32'hC0);
        cyc(1'b0, 1);
        chk({wave_b, wave_a}, 2'b11);
        rchk(tcr_pkg::OFF_FLAGS, 32'h0);
        rchk(tcr_pkg::OFF_COUNT, 32'h12);
        apb(1'b1, tcr_pkg::OFF_CONTROL_A, 32'h71);
        apb(1'b1, tcr_pkg::OFF_CONTROL_B, 32'h00);
        apb(1'b1, tcr_pkg::OFF_CONTROL_B, 32'hC0);
        cyc(1'b0, 1);
        chk({wave_b, wave_a}, 2'b11);
        tally_and_finish();
    end
endmodule : tcr_timer_regs_test
`default_nettype wire
